// ===== hdl/dual_timer_pwm_unit.v
// Two timer/counters with optional PWM output, reached over AHB-Lite.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ns
`include "timer_pwm_regs.vh"

// Notes on behaviour
// - Mode 2: low byte reloads from high byte
// - Mode 3: timer0 low byte uses timer0 controls
// - Mode 3: timer0 high byte runs on timer1 run
// - Mode 0: timer1 low active bits = prescale+1
// - Mode 0: timer0 low active bits = prescale+1
// - Each timer's own enable selects PWM
// - PWM waveform driven on that timer's pin
// - PWM: high count counts, high reload compares
// - Output goes high at count 00H
// - Output goes low at compare match
// - Compare updates only at FFH to 00H wrap
// - Compare 00H holds output low
// - PWM works only in modes 0 and 1
// - Mode 0 PWM: low byte logarithmic prescaler
// - Mode 1 PWM: low byte reloading linear prescaler
// - Quasi or output pin: full push-pull drive
// - Port bit toggling counts as external events except on an input-only pin
// - Gate set: run needs request pin high
module dual_timer_pwm_unit
(
    input wire core_clk_in,
    input wire rst_in,
    input wire hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    output wire hreadyout_out,
    output wire hresp_out,
    output wire [31:0] hrdata_out,
    input wire external_request_pin0_in,
    input wire external_request_pin1_in,
    input wire port_bit_timer0_pin_in,
    input wire port_bit_timer1_pin_in,
    input wire [1:0] timer0_pin_mode_in,
    input wire [1:0] timer1_pin_mode_in,
    input wire timer0_pin_in,
    output wire timer0_pin_out,
    output wire timer0_pin_oe_out,
    input wire timer1_pin_in,
    output wire timer1_pin_out,
    output wire timer1_pin_oe_out
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_WRITE = 4'b0010;
    localparam [3:0] ST_RDWAIT = 4'b0100;
    localparam [3:0] ST_RDDONE = 4'b1000;

    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [7:0] addr_idx_q;
    reg addr_ok_q;
    reg [31:0] hrdata_q;

    reg [7:0] timer_control_q;
    reg [7:0] timer_mode_q;
    reg [7:0] timer_control_second_q;
    reg [7:0] timer0_low_count_q;
    reg [7:0] timer1_low_count_q;
    reg [7:0] timer0_high_count_q;
    reg [7:0] timer1_high_count_q;
    reg [7:0] timer0_reload_low_q;
    reg [7:0] timer1_reload_low_q;
    reg [7:0] timer0_reload_high_q;
    reg [7:0] timer1_reload_high_q;
    reg [7:0] cmp0_q;
    reg [7:0] cmp1_q;
    reg pwm0_q;
    reg pwm1_q;
    reg src0_prev_q;
    reg src1_prev_q;

    wire int0_s;
    wire int1_s;
    wire pin0_s;
    wire pin1_s;

    pin_sync3 u_sync_int0
    (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .async_in(external_request_pin0_in),
        .level_out(int0_s)
    );

    pin_sync3 u_sync_int1
    (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .async_in(external_request_pin1_in),
        .level_out(int1_s)
    );

    pin_sync3 u_sync_pin0
    (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .async_in(timer0_pin_in),
        .level_out(pin0_s)
    );

    pin_sync3 u_sync_pin1
    (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .async_in(timer1_pin_in),
        .level_out(pin1_s)
    );

    // Next count state of one timer: {overflow, high wrap, high, low}.
    function [17:0] step;
        input [1:0] mode;
        input pwm;
        input [2:0] psc;
        input [7:0] l;
        input [7:0] h;
        input [7:0] rl;
        input [7:0] rh;
        reg [7:0] mask;
        reg [7:0] l_n;
        reg [7:0] h_n;
        reg ovf;
        reg hwrap;
        begin
            mask = ~(`BYTE_FULL << ({1'b0, psc} + 4'd1));
            l_n = l + `BYTE_ONE;
            h_n = h;
            ovf = 1'b0;
            hwrap = 1'b0;
            case (mode)
                `MODE_VARIABLE:
                begin
                    if ((l & mask) == mask)
                    begin
                        l_n = l & ~mask;
                        h_n = h + `BYTE_ONE;
                        hwrap = (h == `BYTE_FULL);
                        ovf = ~pwm & (h == `BYTE_FULL);
                    end
                end
                `MODE_CASCADE16:
                begin
                    if (pwm && l == `BYTE_FULL)
                    begin
                        l_n = rl;
                        h_n = h + `BYTE_ONE;
                        hwrap = (h == `BYTE_FULL);
                    end
                    else if (!pwm && {h, l} == `WORD_FULL)
                    begin
                        l_n = rl;
                        h_n = rh;
                        ovf = 1'b1;
                    end
                    else if (!pwm && l == `BYTE_FULL)
                    begin
                        h_n = h + `BYTE_ONE;
                    end
                end
                `MODE_AUTO8:
                begin
                    if (l == `BYTE_FULL)
                    begin
                        l_n = h;
                        ovf = 1'b1;
                    end
                end
                default:
                begin
                    ovf = (l == `BYTE_FULL);
                end
            endcase
            step = {ovf, hwrap, h_n, l_n};
        end
    endfunction

    // Bus slave: writes finish with no wait, reads take one wait state.
    wire take = hsel_in & htrans_in[`HTRANS_ACTIVE_BIT] & hready_in;
    wire addr_ok = (haddr_in[31:10] == `ADDR_UPPER_ZERO) &&
        (haddr_in[1:0] == `ADDR_LANE_ZERO);
    wire wr_en = (state_q == ST_WRITE) & addr_ok_q;

    always @*
    begin
        state_d = ST_IDLE;
        case (state_q)
            ST_RDWAIT:
            begin
                state_d = ST_RDDONE;
            end
            default:
            begin
                if (take)
                begin
                    state_d = hwrite_in ? ST_WRITE : ST_RDWAIT;
                end
            end
        endcase
    end

    function [7:0] rd_mux;
        input [7:0] idx;
        begin
            if (idx == `TIMER_CONTROL_IDX)
                rd_mux = timer_control_q;
            else if (idx == `TIMER_MODE_IDX)
                rd_mux = timer_mode_q;
            else if (idx == `TIMER0_LOW_COUNT_IDX)
                rd_mux = timer0_low_count_q;
            else if (idx == `TIMER1_LOW_COUNT_IDX)
                rd_mux = timer1_low_count_q;
            else if (idx == `TIMER0_HIGH_COUNT_IDX)
                rd_mux = timer0_high_count_q;
            else if (idx == `TIMER1_HIGH_COUNT_IDX)
                rd_mux = timer1_high_count_q;
            else if (idx == `TIMER_CONTROL_SECOND_IDX)
                rd_mux = timer_control_second_q;
            else if (idx == `TIMER0_RELOAD_LOW_IDX)
                rd_mux = timer0_reload_low_q;
            else if (idx == `TIMER1_RELOAD_LOW_IDX)
                rd_mux = timer1_reload_low_q;
            else if (idx == `TIMER0_RELOAD_HIGH_IDX)
                rd_mux = timer0_reload_high_q;
            else if (idx == `TIMER1_RELOAD_HIGH_IDX)
                rd_mux = timer1_reload_high_q;
            else
                rd_mux = `BYTE_ZERO;
        end
    endfunction

    always @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            state_q <= ST_IDLE;
            addr_idx_q <= `BYTE_ZERO;
            addr_ok_q <= 1'b0;
            hrdata_q <= 32'h00000000;
        end
        else
        begin
            state_q <= state_d;
            if (take)
            begin
                addr_idx_q <= haddr_in[9:2];
                addr_ok_q <= addr_ok;
            end
            if (state_q == ST_RDWAIT)
            begin
                hrdata_q <= {24'h000000,
                    addr_ok_q ? rd_mux(addr_idx_q) : `BYTE_ZERO};
            end
        end
    end

    assign hreadyout_out = (state_q != ST_RDWAIT);
    assign hresp_out = 1'b0;
    assign hrdata_out = hrdata_q;

    // Field decode.
    wire [1:0] mode0 = timer_mode_q[`TIMER_MODE_T0_MODE_HI:`TIMER_MODE_T0_MODE_LO];
    wire [1:0] mode1 = timer_mode_q[`TIMER_MODE_T1_MODE_HI:`TIMER_MODE_T1_MODE_LO];
    wire [2:0] timer0_prescale_field = timer_control_second_q[`TCB_TIMER0_PRESCALE_FIELD_HI:`TCB_TIMER0_PRESCALE_FIELD_LO];
    wire [2:0] timer1_prescale_field = timer_control_second_q[`TCB_TIMER1_PRESCALE_FIELD_HI:`TCB_TIMER1_PRESCALE_FIELD_LO];
    wire tr0 = timer_control_q[`TCTL_TR0];
    wire tr1 = timer_control_q[`TCTL_TR1];
    wire t0_split = (mode0 == `MODE_SPLIT);

    wire pwm0_on = timer_control_second_q[`TCB_PWM0_EN] &
        ~mode0[1];
    wire pwm1_on = timer_control_second_q[`TCB_PWM1_EN] &
        ~mode1[1];

    // Count sources; on a driven pin the port bit gates the level.
    wire src0 = (timer0_pin_mode_in == `PIN_INPUT_ONLY) ? pin0_s :
        (pin0_s & port_bit_timer0_pin_in);
    wire src1 = (timer1_pin_mode_in == `PIN_INPUT_ONLY) ? pin1_s :
        (pin1_s & port_bit_timer1_pin_in);
    wire fall0 = src0_prev_q & ~src0;
    wire fall1 = src1_prev_q & ~src1;

    wire run0 = tr0 & (~timer_mode_q[`TIMER_MODE_T0_GATE] | int0_s);
    wire run1 = tr1 & (~timer_mode_q[`TIMER_MODE_T1_GATE] | int1_s) &
        (mode1 != `MODE_SPLIT);
    // Source select must stay clear in PWM; nothing forces it clear, so when it is set a pin edge drives the tick.
    wire tick0 = run0 & (timer_mode_q[`TIMER_MODE_T0_CT] ? fall0 : 1'b1);
    wire tick1 = run1 & (timer_mode_q[`TIMER_MODE_T1_CT] ? fall1 : 1'b1);

    wire [17:0] nxt0 = step(mode0, pwm0_on, timer0_prescale_field, timer0_low_count_q,
        timer0_high_count_q, timer0_reload_low_q, timer0_reload_high_q);
    wire [17:0] nxt1 = step(mode1, pwm1_on, timer1_prescale_field, timer1_low_count_q,
        timer1_high_count_q, timer1_reload_low_q, timer1_reload_high_q);

    // In split mode the timer0 high byte is a plain timer on timer1 run.
    wire h0_split_tick = t0_split & tr1;
    wire [7:0] h0_next = t0_split ?
        (h0_split_tick ? timer0_high_count_q + `BYTE_ONE :
        timer0_high_count_q) :
        (tick0 ? nxt0[15:8] : timer0_high_count_q);
    wire [7:0] l0_next = tick0 ? nxt0[7:0] : timer0_low_count_q;
    wire [7:0] h1_next = tick1 ? nxt1[15:8] : timer1_high_count_q;
    wire [7:0] l1_next = tick1 ? nxt1[7:0] : timer1_low_count_q;
    wire set_tf0 = tick0 & nxt0[17];
    wire set_tf1 = (h0_split_tick & (timer0_high_count_q == `BYTE_FULL)) |
        (tick1 & nxt1[17] & ~t0_split);
    wire wrap0 = tick0 & nxt0[16] & pwm0_on;
    wire wrap1 = tick1 & nxt1[16] & pwm1_on;

    function wr_hit;
        input [7:0] idx;
        begin
            wr_hit = wr_en & (addr_idx_q == idx);
        end
    endfunction

    wire [7:0] wdata = hwdata_in[7:0];

    always @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            timer_control_q <= `BYTE_ZERO;
            timer_mode_q <= `BYTE_ZERO;
            timer_control_second_q <= `TIMER_CONTROL_SECOND_RESET;
            timer0_low_count_q <= `BYTE_ZERO;
            timer1_low_count_q <= `BYTE_ZERO;
            timer0_high_count_q <= `BYTE_ZERO;
            timer1_high_count_q <= `BYTE_ZERO;
            timer0_reload_low_q <= `BYTE_ZERO;
            timer1_reload_low_q <= `BYTE_ZERO;
            timer0_reload_high_q <= `BYTE_ZERO;
            timer1_reload_high_q <= `BYTE_ZERO;
            cmp0_q <= `BYTE_ZERO;
            cmp1_q <= `BYTE_ZERO;
            src0_prev_q <= 1'b0;
            src1_prev_q <= 1'b0;
        end
        else
        begin
            src0_prev_q <= src0;
            src1_prev_q <= src1;
            // Overflow flags: a hardware set wins over a software clear.
            if (wr_hit(`TIMER_CONTROL_IDX))
                timer_control_q <= wdata |
                    {set_tf1, 1'b0, set_tf0, 5'h00};
            else
                timer_control_q <= timer_control_q |
                    {set_tf1, 1'b0, set_tf0, 5'h00};
            if (wr_hit(`TIMER_MODE_IDX))
                timer_mode_q <= wdata;
            if (wr_hit(`TIMER_CONTROL_SECOND_IDX))
                timer_control_second_q <= wdata;
            timer0_low_count_q <= wr_hit(`TIMER0_LOW_COUNT_IDX) ?
                wdata : l0_next;
            timer1_low_count_q <= wr_hit(`TIMER1_LOW_COUNT_IDX) ?
                wdata : l1_next;
            timer0_high_count_q <= wr_hit(`TIMER0_HIGH_COUNT_IDX) ?
                wdata : h0_next;
            timer1_high_count_q <= wr_hit(`TIMER1_HIGH_COUNT_IDX) ?
                wdata : h1_next;
            if (wr_hit(`TIMER0_RELOAD_LOW_IDX))
                timer0_reload_low_q <= wdata;
            if (wr_hit(`TIMER1_RELOAD_LOW_IDX))
                timer1_reload_low_q <= wdata;
            if (wr_hit(`TIMER0_RELOAD_HIGH_IDX))
                timer0_reload_high_q <= wdata;
            if (wr_hit(`TIMER1_RELOAD_HIGH_IDX))
                timer1_reload_high_q <= wdata;
            // While PWM runs the compare copy changes only at the wrap.
            if (!pwm0_on || wrap0)
                cmp0_q <= timer0_reload_high_q;
            if (!pwm1_on || wrap1)
                cmp1_q <= timer1_reload_high_q;
        end
    end

    // Waveform: high at count zero, low at the compare match.
    wire [7:0] cmp0_use = wrap0 ? timer0_reload_high_q : cmp0_q;
    wire [7:0] cmp1_use = wrap1 ? timer1_reload_high_q : cmp1_q;

    always @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            pwm0_q <= 1'b0;
            pwm1_q <= 1'b0;
        end
        else
        begin
            if (cmp0_use == `BYTE_ZERO)
                pwm0_q <= 1'b0;
            else if (timer0_high_count_q == cmp0_use)
                pwm0_q <= 1'b0;
            else if (timer0_high_count_q == `BYTE_ZERO)
                pwm0_q <= 1'b1;
            if (cmp1_use == `BYTE_ZERO)
                pwm1_q <= 1'b0;
            else if (timer1_high_count_q == cmp1_use)
                pwm1_q <= 1'b0;
            else if (timer1_high_count_q == `BYTE_ZERO)
                pwm1_q <= 1'b1;
        end
    end

    // Pin drive follows the port's configuration, which software sets.
    wire pp0 = (timer0_pin_mode_in == `PIN_QUASI) ||
        (timer0_pin_mode_in == `PIN_PUSH_PULL);
    wire pp1 = (timer1_pin_mode_in == `PIN_QUASI) ||
        (timer1_pin_mode_in == `PIN_PUSH_PULL);
    wire od0 = (timer0_pin_mode_in == `PIN_OPEN_DRAIN);
    wire od1 = (timer1_pin_mode_in == `PIN_OPEN_DRAIN);

    assign timer0_pin_out = pp0 & pwm0_q;
    assign timer0_pin_oe_out = pwm0_on & (pp0 | (od0 & ~pwm0_q));
    assign timer1_pin_out = pp1 & pwm1_q;
    assign timer1_pin_oe_out = pwm1_on & (pp1 | (od1 & ~pwm1_q));
endmodule

// ===== hdl/timer_pwm_regs.vh
// Register indices, field positions, reset values and encodings of the timers.
`ifndef TIMER_PWM_REGS_VH
`define TIMER_PWM_REGS_VH

`define TIMER_CONTROL_IDX 8'h88
`define TIMER_MODE_IDX 8'h89
`define TIMER0_LOW_COUNT_IDX 8'h8a
`define TIMER1_LOW_COUNT_IDX 8'h8b
`define TIMER0_HIGH_COUNT_IDX 8'h8c
`define TIMER1_HIGH_COUNT_IDX 8'h8d
`define TIMER_CONTROL_SECOND_IDX 8'h91
`define TIMER0_RELOAD_LOW_IDX 8'h92
`define TIMER1_RELOAD_LOW_IDX 8'h93
`define TIMER0_RELOAD_HIGH_IDX 8'h94
`define TIMER1_RELOAD_HIGH_IDX 8'h95

`define ADDR_UPPER_ZERO 22'h000000
`define ADDR_LANE_ZERO 2'h0

`define TCTL_TF1 7
`define TCTL_TR1 6
`define TCTL_TF0 5
`define TCTL_TR0 4

`define TIMER_MODE_T1_GATE 7
`define TIMER_MODE_T1_CT 6
`define TIMER_MODE_T1_MODE_HI 5
`define TIMER_MODE_T1_MODE_LO 4
`define TIMER_MODE_T0_GATE 3
`define TIMER_MODE_T0_CT 2
`define TIMER_MODE_T0_MODE_HI 1
`define TIMER_MODE_T0_MODE_LO 0

`define TCB_PWM1_EN 7
`define TCB_PWM0_EN 6
`define TCB_TIMER1_PRESCALE_FIELD_HI 5
`define TCB_TIMER1_PRESCALE_FIELD_LO 3
`define TCB_TIMER0_PRESCALE_FIELD_HI 2
`define TCB_TIMER0_PRESCALE_FIELD_LO 0

`define TIMER_CONTROL_SECOND_RESET 8'h24
`define BYTE_ZERO 8'h00
`define BYTE_FULL 8'hff
`define WORD_FULL 16'hffff
`define BYTE_ONE 8'h01

`define MODE_VARIABLE 2'h0
`define MODE_CASCADE16 2'h1
`define MODE_AUTO8 2'h2
`define MODE_SPLIT 2'h3

`define PIN_QUASI 2'h0
`define PIN_PUSH_PULL 2'h1
`define PIN_INPUT_ONLY 2'h2
`define PIN_OPEN_DRAIN 2'h3

`define HTRANS_ACTIVE_BIT 1

`endif

// ===== hdl/pin_sync3.v
// Three-stage input synchroniser whose output changes once stages two and three agree.
`timescale 1ns/1ns
module pin_sync3
(
    input wire core_clk_in,
    input wire rst_in,
    input wire async_in,
    output wire level_out
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg level_q;

    always @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end
        else
        begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
            begin
                level_q <= s3_q;
            end
        end
    end

    assign level_out = level_q;
endmodule

// ===== dv/dual_timer_pwm_unit_props.sv
// Concurrent checks on the bus and timer pin ports of the timer unit.
`timescale 1ns/1ns
module timer_pwm_props
(
    input wire core_clk_in,
    input wire rst_in,
    input wire hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire hready_in,
    input wire hreadyout_out,
    input wire hresp_out,
    input wire [31:0] hrdata_out,
    input wire [1:0] timer0_pin_mode_in,
    input wire [1:0] timer1_pin_mode_in,
    input wire timer0_pin_out,
    input wire timer0_pin_oe_out,
    input wire timer1_pin_out,
    input wire timer1_pin_oe_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    wire take = hsel_in & htrans_in[1] & hready_in;
    wire bad = (haddr_in[31:10] != 22'h000000) || (haddr_in[9:2] == 8'h90);
    sequence s_wait_one;
        !hreadyout_out ##1 hreadyout_out;
    endsequence
    property p_off(logic [1:0] m, logic [1:0] k, logic v);
        (m == k && $past(m) == k && $past(m, 2) == k) |-> !v;
    endproperty
    chk_read_wait: assert property (take && !hwrite_in |=> s_wait_one)
        else $error("read data phase not one wait state");
    chk_write_nowait: assert property (take && hwrite_in |=> hreadyout_out)
        else $error("write data phase stalled");
    chk_bad_zero: assert property (take && !hwrite_in && bad
        |=> ##1 hrdata_out == 32'h00000000)
        else $error("unmapped read not zero");
    chk_upper_zero: assert property (hrdata_out[31:8] == 24'h000000)
        else $error("read data upper bits set");
    chk_resp_okay: assert property (!hresp_out)
        else $error("error response seen");
    chk_reset_quiet: assert property (disable iff (1'b0)
        rst_in |=> hreadyout_out && !timer0_pin_oe_out && !timer1_pin_oe_out)
        else $error("outputs active after reset");
    chk_input_only0: assert property (p_off(timer0_pin_mode_in, 2'h2,
        timer0_pin_oe_out))
        else $error("timer0 pin driven in input-only");
    chk_input_only1: assert property (p_off(timer1_pin_mode_in, 2'h2,
        timer1_pin_oe_out))
        else $error("timer1 pin driven in input-only");
    chk_open_drain0: assert property (p_off(timer0_pin_mode_in, 2'h3,
        timer0_pin_out))
        else $error("timer0 open-drain pin driven high");
endmodule
bind dual_timer_pwm_unit timer_pwm_props u_props
(
    .core_clk_in(core_clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hready_in(hready_in), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .hrdata_out(hrdata_out),
    .timer0_pin_mode_in(timer0_pin_mode_in),
    .timer1_pin_mode_in(timer1_pin_mode_in),
    .timer0_pin_out(timer0_pin_out), .timer0_pin_oe_out(timer0_pin_oe_out),
    .timer1_pin_out(timer1_pin_out), .timer1_pin_oe_out(timer1_pin_oe_out)
);

// ===== dv/timer_pin_partner.sv
// Model of the external count sources and pull-ups on the timer pins.
`timescale 1ns/1ns
module timer_pin_partner
(
    input wire core_clk_in,
    input wire out0_in,
    input wire oe0_in,
    input wire out1_in,
    input wire oe1_in,
    output wire lvl0_out,
    output wire lvl1_out
);
    logic drv0 = 1'b1;
    logic drv1 = 1'b1;
    // A released pin is pulled up; the unit wins while it drives.
    assign lvl0_out = oe0_in ? out0_in : drv0;
    assign lvl1_out = oe1_in ? out1_in : drv1;
    task pulses(input int s, input int n);
        repeat (n)
        begin
            if (s == 1) drv1 <= 1'b0; else drv0 <= 1'b0;
            repeat (4) @(posedge core_clk_in);
            if (s == 1) drv1 <= 1'b1; else drv0 <= 1'b1;
            repeat (4) @(posedge core_clk_in);
        end
    endtask
endmodule

// ===== dv/dual_timer_pwm_unit_test.sv
// Self-checking bench for the dual timer and PWM unit.
`timescale 1ns/1ns
module dual_timer_pwm_unit_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] haddr = 32'h00000000;
    logic [31:0] hwdata = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic req0 = 1'b0;
    logic req1 = 1'b0;
    logic pb0 = 1'b1;
    logic pb1 = 1'b1;
    logic [1:0] pm0 = 2'h1;
    logic [1:0] pm1 = 2'h2;
    wire hrdy, hresp, out0, oe0, out1, oe1, lvl0, lvl1;
    wire [31:0] hrdata;
    wire [1:0] pins = {out1, out0};
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int w, h;
    logic [31:0] v;
    logic [7:0] regs [11] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
        8'h91, 8'h92, 8'h93, 8'h94, 8'h95};
    dual_timer_pwm_unit uut
    (
        .core_clk_in(clk), .rst_in(rst), .hsel_in(1'b1), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hrdy), .hreadyout_out(hrdy),
        .hresp_out(hresp), .hrdata_out(hrdata),
        .external_request_pin0_in(req0), .external_request_pin1_in(req1),
        .port_bit_timer0_pin_in(pb0), .port_bit_timer1_pin_in(pb1),
        .timer0_pin_mode_in(pm0), .timer1_pin_mode_in(pm1),
        .timer0_pin_in(lvl0), .timer0_pin_out(out0), .timer0_pin_oe_out(oe0),
        .timer1_pin_in(lvl1), .timer1_pin_out(out1), .timer1_pin_oe_out(oe1)
    );
    timer_pin_partner far
    (
        .core_clk_in(clk), .out0_in(out0), .oe0_in(oe0), .out1_in(out1),
        .oe1_in(oe1), .lvl0_out(lvl0), .lvl1_out(lvl1)
    );
    initial forever #10 clk = ~clk;
    task final_report;
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            final_report;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] lo, hi);
        logic ok;
        ok = (got >= lo) && (got <= hi);
        n_tests++;
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, lo);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task bus(input logic wr, input logic [7:0] i, input logic [7:0] d);
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= {22'h000000, i, 2'h0};
        hwrite <= wr;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do @(posedge clk); while (hrdy !== 1'b1);
        v = hrdata;
    endtask
    task wr(input logic [7:0] i, input logic [7:0] d);
        bus(1'b1, i, d);
    endtask
    task rd(input logic [7:0] i);
        bus(1'b0, i, 8'h00);
    endtask
    task wait_lvl(input int s, input logic b);
        int k;
        k = 0;
        while (pins[s] !== b && k < 2000)
        begin
            @(posedge clk);
            k++;
        end
    endtask
    task high_len(input int s);
        w = 0;
        while (pins[s] === 1'b1 && w < 300)
        begin
            @(posedge clk);
            w++;
        end
    endtask
    task pwm_width(input int s);
        wait_lvl(s, 1'b0);
        wait_lvl(s, 1'b1);
        high_len(s);
    endtask
    initial
    begin
        step(10);
        rst <= 1'b0;
        foreach (regs[k])
        begin
            rd(regs[k]);
            chk(v, (k == 6) ? 8'h24 : 8'h00, (k == 6) ? 8'h24 : 8'h00);
        end
        wr(8'h90, 8'h5a);
        rd(8'h90); chk(v, 0, 0);
        wr(8'h92, 8'ha5);
        rd(8'h92); chk(v, 8'ha5, 8'ha5);
        $display("Test reset and access done");
        wr(8'h89, 8'h02); wr(8'h8c, 8'h80); wr(8'h8a, 8'hfe);
        wr(8'h88, 8'h10); step(30);
        rd(8'h88); chk(v & 8'h30, 8'h30, 8'h30);
        wr(8'h88, 8'h00);
        rd(8'h8a); chk(v, 8'h80, 8'hbf);
        wr(8'h89, 8'h10); wr(8'h8d, 8'hff); wr(8'h8b, 8'hf0);
        wr(8'h93, 8'h12); wr(8'h95, 8'h34); wr(8'h88, 8'h40); step(30);
        wr(8'h88, 8'h00);
        rd(8'h8d); chk(v, 8'h34, 8'h34);
        rd(8'h8b); chk(v, 8'h12, 8'h40);
        $display("Test modes 1 and 2 done");
        wr(8'h91, 8'h20); wr(8'h89, 8'h00); wr(8'h8a, 8'h00);
        wr(8'h8c, 8'h00); wr(8'h88, 8'h10); step(40); wr(8'h88, 8'h00);
        rd(8'h8c); chk(v, 8'h12, 8'h1a);
        rd(8'h8a); chk(v, 0, 1);
        wr(8'h8b, 8'h00); wr(8'h8d, 8'h00); wr(8'h88, 8'h40); step(100);
        wr(8'h88, 8'h00);
        rd(8'h8b); chk(v, 0, 8'h1f);
        rd(8'h8d); chk(v, 2, 4);
        wr(8'h89, 8'h33); wr(8'h8a, 8'h55); wr(8'h8c, 8'h00);
        wr(8'h8b, 8'h66); wr(8'h8d, 8'h77); wr(8'h88, 8'h40); step(20);
        wr(8'h88, 8'h00);
        rd(8'h8c); chk(v, 8'h10, 8'h20);
        rd(8'h8a); chk(v, 8'h55, 8'h55);
        rd(8'h8b); chk(v, 8'h66, 8'h66);
        rd(8'h8d); chk(v, 8'h77, 8'h77);
        wr(8'h88, 8'h10); step(20); wr(8'h88, 8'h00);
        rd(8'h8a); chk(v, 8'h60, 8'h75);
        $display("Test modes 0 and 3 done");
        wr(8'h89, 8'h90); wr(8'h8b, 8'h00); wr(8'h8d, 8'h00);
        wr(8'h88, 8'h40); step(20);
        rd(8'h8b); chk(v, 0, 0);
        req1 <= 1'b1;
        step(20); wr(8'h88, 8'h00);
        rd(8'h8b); chk(v, 8'h08, 8'h30);
        wr(8'h89, 8'h05); wr(8'h8a, 8'h00); wr(8'h8c, 8'h00);
        wr(8'h88, 8'h10);
        far.pulses(0, 5); step(10);
        rd(8'h8a); chk(v, 5, 5);
        pm0 <= 2'h2;
        pb0 <= 1'b0;
        step(5); far.pulses(0, 3); step(10);
        rd(8'h8a); chk(v, 8, 8);
        pm0 <= 2'h0;
        pb0 <= 1'b1;
        step(5);
        repeat (2)
        begin
            pb0 <= 1'b0; step(4);
            pb0 <= 1'b1; step(4);
        end
        step(10);
        rd(8'h8a); chk(v, 10, 10);
        wr(8'h88, 8'h00);
        $display("Test gating and counting done");
        pm0 <= 2'h1;
        wr(8'h94, 8'h40); wr(8'h92, 8'hff); wr(8'h8a, 8'h00);
        wr(8'h8c, 8'h00); wr(8'h89, 8'h01);
        wr(8'h91, 8'h64); wr(8'h88, 8'h10);
        pwm_width(0); chk(w, 8'h40, 8'h40);
        chk(oe0, 1, 1);
        wait_lvl(0, 1'b0); wait_lvl(0, 1'b1);
        fork
            high_len(0);
            wr(8'h94, 8'h20);
        join
        chk(w, 8'h40, 8'h40);
        pwm_width(0); chk(w, 8'h20, 8'h20);
        wr(8'h94, 8'h00); step(300);
        h = 0;
        repeat (300)
        begin
            @(posedge clk);
            if (out0 !== 1'b0) h++;
        end
        chk(h, 0, 0);
        pm0 <= 2'h3; step(5);
        chk(oe0, 1, 1); chk(lvl0, 0, 0);
        pm0 <= 2'h2; step(5); chk(oe0, 0, 0);
        pm0 <= 2'h1; wr(8'h89, 8'h02); step(5);
        chk(oe0, 0, 0);
        wr(8'h95, 8'h10); wr(8'h91, 8'h84); wr(8'h93, 8'hff);
        wr(8'h8b, 8'h00); wr(8'h8d, 8'h00); wr(8'h89, 8'h10);
        pm1 <= 2'h1;
        wr(8'h88, 8'h40);
        pwm_width(1); chk(w, 8'h10, 8'h10);
        chk(oe1, 1, 1); chk(oe0, 0, 0);
        $display("Test pulse width modulation done");
        final_report;
    end
endmodule
